// ---- logic/system_interrupt_controller.sv ----
`timescale 1ns/100ps
// Behaviour
// - all nine sources can raise interrupt
// - status bit per source, fixed positions
// - flag sets on event, resets to zero
// - reading status clears latched flags
// - still-active source stays set after read
// - mask gates output only, flag still latches
// - mask bits align status, one masks
// - output is OR of unmasked flags
// - global mask forces output off, resets set
// - polarity picks rising or falling edge
// - both-edge mode fires on either edge
// - pin inputs de-bounced on timeout clock
// - interrupt output routable to any pin
// - status readable at any time
// - function 0011 drives interrupt onto pin
// - function 0000 level, 0001 edge event
module system_interrupt_controller #(
  parameter int unsigned TIMEOUT_DIV = sic_pkg::TIMEOUT_CYCLES,
  parameter int unsigned DEBOUNCE_LEN = sic_pkg::DEBOUNCE_TICKS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input sic_pkg::reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [3:0] pin_level,
  input sic_pkg::pin_cfg_t [3:0] pin_cfg,
  input sic_pkg::core_events_t core_events,
  input wire logic timeout_clock_enable,
  input wire logic oscillator_clock_enable,
  output logic irq_out,
  output logic [3:0] pin_irq_out,
  output logic [3:0] pin_irq_oe_n
);
  import sic_pkg::*;

  localparam int unsigned DW = (TIMEOUT_DIV > 1) ? $clog2(TIMEOUT_DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(TIMEOUT_DIV - 1);

  if (TIMEOUT_DIV < 1 || DEBOUNCE_LEN < 1) begin : g_bad
    $error("timeout divider and debounce length must be at least one");
  end

  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic global_q;
  logic global_d;
  logic [DW-1:0] div_q;
  logic [DW-1:0] div_d;
  logic tick_q;
  logic [3:0] stable;
  logic [3:0] prev_q;
  logic [3:0] pin_event;
  logic [15:0] set_vec;
  logic [15:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic [3:0] pin_out_q;
  logic [3:0] pin_oe_n_q;
  logic rdata_valid_q;
  logic [15:0] rdata_q;

  // timeout clock: stopped unless software turned both enables on
  wire clocks_on = timeout_clock_enable && oscillator_clock_enable;
  assign div_d = (!clocks_on || div_q == DIV_LAST) ? '0 : div_q + DW'(1);
  wire tick_d = clocks_on && (div_q == DIV_LAST);

  wire hit_status = reg_req.addr == ADDR_STATUS;
  wire hit_config = reg_req.addr == ADDR_CONFIG;
  wire hit_mask = reg_req.addr == ADDR_MASK;
  wire status_rd = reg_req.rd_en && hit_status;

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    wire adj_now = stable[i] ^ pin_cfg[i].polarity_invert;
    wire adj_prev = prev_q[i] ^ pin_cfg[i].polarity_invert;
    wire is_level = pin_cfg[i].func == FN_LEVEL_IN;
    wire is_edge = pin_cfg[i].func == FN_EDGE_IN;
    wire rise = adj_now && !adj_prev;
    wire any_edge = stable[i] != prev_q[i];
    wire edge_ev = pin_cfg[i].both_edge ? any_edge : rise;

    pin_debounce #(.TICKS(DEBOUNCE_LEN)) u_deb (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(tick_q),
      .raw(pin_level[i]),
      .stable_q(stable[i])
    );

    assign pin_event[i] = (is_level && adj_now) || (is_edge && edge_ev);
    // routed output ignores polarity: the host always sees it active high

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        pin_out_q[i] <= 1'b0;
        pin_oe_n_q[i] <= 1'b1;
      end else begin
        pin_out_q[i] <= irq_d && (pin_cfg[i].func == FN_IRQ_OUT);
        pin_oe_n_q[i] <= pin_cfg[i].func != FN_IRQ_OUT;
      end
    end

    a_pin_route: assert property (@(posedge sys_clk) disable iff (rst)
      pin_cfg[i].func == FN_IRQ_OUT |=> !pin_oe_n_q[i] && pin_out_q[i] == irq_q)
      else $error("pin set for interrupt output does not mirror it");
    // a pin not routed must let go of its line, or it fights the far end
    a_pin_released: assert property (@(posedge sys_clk) disable iff (rst)
      pin_cfg[i].func != FN_IRQ_OUT |=> pin_oe_n_q[i] && !pin_out_q[i])
      else $error("pin not set for interrupt output still drives");
  end

  always_comb begin
    set_vec = '0;
    set_vec[BIT_THERMAL] = core_events.thermal;
    set_vec[BIT_PIN1 +: NUM_PINS] = pin_event;
    set_vec[BIT_TOUCH_DATA] = core_events.touch_data;
    set_vec[BIT_PEN_CONTACT] = core_events.pen_contact;
    set_vec[BIT_AUX_DONE] = core_events.aux_done;
    set_vec[BIT_UNDERVOLT] = core_events.undervolt;
  end

  // new events win over the clear of a read in the same cycle
  assign status_d = set_vec | (status_q & ~{16{status_rd}});
  assign mask_d = (reg_req.wr_en && hit_mask) ? (reg_req.wdata & STATUS_IMPL) : mask_q;
  assign global_d = (reg_req.wr_en && hit_config) ? reg_req.wdata[BIT_GLOBAL_MASK] : global_q;
  // built from the registered flags so the pins and irq_out move together
  assign irq_d = (|(status_q & ~mask_q)) && !global_q;

  // unmapped addresses read zero rather than stale data
  assign rdata_d = hit_status ? status_q :
                   hit_config ? {15'h0000, global_q} :
                   hit_mask ? mask_q : 16'h0000;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_q <= STATUS_RESET;
      mask_q <= MASK_RESET;
      global_q <= GLOBAL_MASK_RESET;
      div_q <= '0;
      tick_q <= 1'b0;
      prev_q <= '0;
      irq_q <= 1'b0;
      rdata_q <= '0;
      rdata_valid_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      global_q <= global_d;
      div_q <= div_d;
      tick_q <= tick_d;
      prev_q <= stable;
      irq_q <= irq_d;
      rdata_q <= reg_req.rd_en ? rdata_d : rdata_q;
      rdata_valid_q <= reg_req.rd_en;
    end
  end

  assign irq_out = irq_q;
  assign pin_irq_out = pin_out_q;
  assign pin_irq_oe_n = pin_oe_n_q;
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rdata_valid_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_flags_hold: assert property (!status_rd |=> (status_q & $past(status_q)) == $past(status_q))
    else $error("status flag dropped without a read");
  a_read_clears: assert property (status_rd && set_vec == 16'h0000 |=> status_q == 16'h0000)
    else $error("status read did not clear flags");
  a_read_keeps_live: assert property (status_rd |=> (status_q & $past(set_vec)) == $past(set_vec))
    else $error("active source lost on status read");
  a_masked_latches: assert property ((set_vec & mask_q) != 16'h0000
    |=> (status_q & $past(set_vec & mask_q)) == $past(set_vec & mask_q))
    else $error("masked source failed to latch");
  a_read_returns: assert property (status_rd |=> reg_rvalid && reg_rdata == $past(status_q))
    else $error("status read returned wrong value");
  a_global_off: assert property (global_q |=> !irq_out)
    else $error("output active while globally masked");
  a_none_unmasked: assert property ((status_q & ~mask_q) == 16'h0000 |=> !irq_out)
    else $error("output active with no unmasked flag");
  a_or_drives: assert property (!global_q && (status_q & ~mask_q) != 16'h0000 |=> irq_out)
    else $error("unmasked flag did not raise output");
  a_after_reset: assert property ($past(rst) |-> global_q && mask_q == 16'h0000
    && status_q == 16'h0000)
    else $error("wrong register values after reset");
  a_mask_write: assert property (reg_req.wr_en && hit_mask
    |=> mask_q == ($past(reg_req.wdata) & STATUS_IMPL))
    else $error("mask write not stored");
  a_config_write: assert property (reg_req.wr_en && hit_config
    |=> global_q == $past(reg_req.wdata[BIT_GLOBAL_MASK]))
    else $error("global mask write not stored");
  a_rvalid_pulse: assert property (!reg_req.rd_en |=> !reg_rvalid)
    else $error("read data flagged valid without a read");
  a_edge_sets: assert property (pin_cfg[0].func == FN_EDGE_IN && !pin_cfg[0].both_edge
    && g_pin[0].rise |=> status_q[BIT_PIN1])
    else $error("pin edge did not set its flag");
  a_inverted_edge: assert property (pin_cfg[1].func == FN_EDGE_IN
    && pin_cfg[1].polarity_invert && !pin_cfg[1].both_edge
    && prev_q[1] && !stable[1] |=> status_q[BIT_PIN1 + 1])
    else $error("inverted pin missed a falling edge");
  a_both_edges: assert property (pin_cfg[2].func == FN_EDGE_IN && pin_cfg[2].both_edge
    && stable[2] != prev_q[2] |=> status_q[BIT_PIN1 + 2])
    else $error("both-edge mode missed an edge");
  a_level_sets: assert property (pin_cfg[3].func == FN_LEVEL_IN
    && (stable[3] ^ pin_cfg[3].polarity_invert) |=> status_q[BIT_PIN1 + 3])
    else $error("level input did not set its flag");
  a_tick_gated: assert property (!clocks_on |=> !tick_q)
    else $error("timeout tick without clock enables");

  c_irq_rises: cover property ($rose(irq_out));
  c_read_clears: cover property (status_rd && status_q != 16'h0000 ##1 status_q == 16'h0000);
  c_pin_edge: cover property (pin_cfg[0].func == FN_EDGE_IN && g_pin[0].rise);
  c_read_event: cover property (status_rd && set_vec != 16'h0000);
  c_masked_latch: cover property ((set_vec & mask_q) != 16'h0000 && !global_q);
endmodule

// ---- logic/sic_pkg.sv ----
package sic_pkg;
  localparam int unsigned SYS_CLK_PERIOD_NS = 5;
  localparam int unsigned TIMEOUT_PERIOD_NS = 1000;
  localparam int unsigned TIMEOUT_CYCLES =
    (TIMEOUT_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_TICKS = 4;
  localparam int unsigned NUM_PINS = 4;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 16;

  localparam logic [14:0] ADDR_STATUS = 15'h0010;
  localparam logic [14:0] ADDR_CONFIG = 15'h0012;
  localparam logic [14:0] ADDR_MASK = 15'h0013;

  localparam int unsigned BIT_THERMAL = 15;
  localparam int unsigned BIT_PIN1 = 11;
  localparam int unsigned BIT_TOUCH_DATA = 10;
  localparam int unsigned BIT_PEN_CONTACT = 9;
  localparam int unsigned BIT_AUX_DONE = 8;
  localparam int unsigned BIT_UNDERVOLT = 0;
  localparam int unsigned BIT_GLOBAL_MASK = 0;

  localparam logic [15:0] STATUS_IMPL = 16'hff01;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic GLOBAL_MASK_RESET = 1'b1;

  localparam logic [3:0] FN_LEVEL_IN = 4'h0;
  localparam logic [3:0] FN_EDGE_IN = 4'h1;
  localparam logic [3:0] FN_IRQ_OUT = 4'h3;

  typedef struct packed {
    logic [3:0] func;
    logic polarity_invert;
    logic both_edge;
  } pin_cfg_t;

  typedef struct packed {
    logic thermal;
    logic touch_data;
    logic pen_contact;
    logic aux_done;
    logic undervolt;
  } core_events_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [14:0] addr;
    logic [15:0] wdata;
  } reg_req_t;
endpackage

// ---- logic/pin_debounce.sv ----
`timescale 1ns/100ps
module pin_debounce #(
  parameter int unsigned TICKS = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic raw,
  output logic stable_q
);
  import sic_pkg::*;

  localparam int unsigned CW = (TICKS > 1) ? $clog2(TICKS) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

  if (TICKS < 1) begin : g_bad
    $error("pin_debounce needs at least one tick");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic stable_d;
  wire differs = raw != stable_q;
  wire accept = tick && differs && (cnt_q == LAST);

  // a new level is taken only after TICKS consecutive differing samples
  assign cnt_d = (!tick) ? cnt_q : (!differs || accept) ? '0 : cnt_q + CW'(1);
  assign stable_d = accept ? raw : stable_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
      stable_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      stable_q <= stable_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_change_needs_tick: assert property ($changed(stable_q) |-> $past(tick))
    else $error("debounced level moved without a timeout tick");
endmodule

// ---- bench/host_pin_model.sv ----
`timescale 1ns/100ps
module host_pin_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] pin_irq_out,
  input wire logic [3:0] pin_irq_oe_n,
  output logic [3:0] pin_wire,
  output logic irq_seen
);
  logic [3:0] last_q;
  // undriven pins show the inverse of the last level, so a stale value never passes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_wire[i] = !pin_irq_oe_n[i] ? pin_irq_out[i] : ~last_q[i];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      last_q <= 4'h0;
    end else begin
      last_q <= pin_wire;
    end
  end
  // host may poll status at any time or react to the pin
  assign irq_seen = |(pin_wire & ~pin_irq_oe_n);
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/100ps
module tb;
  import sic_pkg::*;
  typedef struct packed {
    core_events_t ev;
    logic [15:0] mask;
    logic [15:0] st;
    logic irq;
  } row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t reg_req = '0;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic [3:0] pin_level = 4'h0;
  pin_cfg_t [3:0] pin_cfg = {6'b000000, 6'b000101, 6'b000110, 6'b000100};
  core_events_t core_events = '0;
  logic timeout_en = 1'b1;
  logic osc_en = 1'b1;
  logic irq_out;
  logic [3:0] pin_irq_out, pin_irq_oe_n, pin_wire;
  logic irq_seen;
  logic [15:0] d;
  int fail_count = 0;
  int checks = 0;
  row_t rows [7] = '{
    '{5'b10000, 16'h0000, 16'h8000, 1'b1}, '{5'b01000, 16'h0000, 16'h0400, 1'b1},
    '{5'b00100, 16'h0000, 16'h0200, 1'b1}, '{5'b00010, 16'h0000, 16'h0100, 1'b1},
    '{5'b00001, 16'h0000, 16'h0001, 1'b1}, '{5'b10000, 16'h8000, 16'h8000, 1'b0},
    '{5'b01010, 16'h0400, 16'h0500, 1'b1}};
  always #2.5 sys_clk = ~sys_clk;
  system_interrupt_controller #(.TIMEOUT_DIV(2), .DEBOUNCE_LEN(1)) u_system_interrupt_controller (
    .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pin_level(pin_level), .pin_cfg(pin_cfg),
    .core_events(core_events), .timeout_clock_enable(timeout_en),
    .oscillator_clock_enable(osc_en), .irq_out(irq_out), .pin_irq_out(pin_irq_out),
    .pin_irq_oe_n(pin_irq_oe_n));
  host_pin_model u_host_pin_model (.sys_clk(sys_clk), .rst(rst), .pin_irq_out(pin_irq_out),
    .pin_irq_oe_n(pin_irq_oe_n), .pin_wire(pin_wire), .irq_seen(irq_seen));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [14:0] a, input logic [15:0] v);
    @(negedge sys_clk) reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: v};
    @(negedge sys_clk) reg_req.wr_en = 1'b0;
  endtask
  task automatic reg_rd(input logic [14:0] a, output logic [15:0] v);
    @(negedge sys_clk) reg_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge sys_clk) chk("rvalid", {15'h0, reg_rvalid}, 16'h0001);
    v = reg_rdata;
    reg_req.rd_en = 1'b0;
  endtask
  task automatic rd_chk(input string name, input logic [14:0] a, input logic [15:0] exp);
    logic [15:0] v;
    reg_rd(a, v);
    chk(name, v, exp);
  endtask
  task automatic irq_chk(input logic exp);
    repeat (2) @(negedge sys_clk);
    chk("irq_out", {15'h0, irq_out}, {15'h0, exp});
  endtask
  // debounce needs one tick every two cycles, 30 cycles leaves ample margin
  task automatic pin_step(input int i, input logic lvl, input logic [15:0] exp);
    @(negedge sys_clk) pin_level[i] = lvl;
    repeat (30) @(negedge sys_clk);
    rd_chk("status pin", ADDR_STATUS, exp);
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    give_verdict;
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    rd_chk("config reset", ADDR_CONFIG, 16'h0001);
    rd_chk("mask reset", ADDR_MASK, 16'h0000);
    rd_chk("unmapped", 15'h0011, 16'h0000);
    @(negedge sys_clk) core_events = 5'b10000;
    @(negedge sys_clk) core_events = '0;
    irq_chk(1'b0);
    rd_chk("status masked", ADDR_STATUS, 16'h8000);
    reg_wr(ADDR_MASK, 16'hffff);
    rd_chk("mask bits", ADDR_MASK, 16'hff01);
    reg_wr(ADDR_CONFIG, 16'h0000);
    foreach (rows[k]) begin
      reg_wr(ADDR_MASK, rows[k].mask);
      @(negedge sys_clk) core_events = rows[k].ev;
      @(negedge sys_clk) core_events = '0;
      irq_chk(rows[k].irq);
      rd_chk("status row", ADDR_STATUS, rows[k].st);
      irq_chk(1'b0);
    end
    reg_wr(ADDR_MASK, 16'h0000);
    @(negedge sys_clk) core_events = 5'b00001;
    rd_chk("status held", ADDR_STATUS, 16'h0001);
    rd_chk("status held", ADDR_STATUS, 16'h0001);
    irq_chk(1'b1);
    core_events = '0;
    reg_rd(ADDR_STATUS, d);
    @(negedge sys_clk) timeout_en = 1'b0;
    pin_step(0, 1'b1, 16'h0000);
    @(negedge sys_clk) timeout_en = 1'b1;
    pin_step(0, 1'b1, 16'h0800);
    pin_step(0, 1'b0, 16'h0000);
    pin_step(1, 1'b1, 16'h0000);
    pin_step(1, 1'b0, 16'h1000);
    pin_step(2, 1'b1, 16'h2000);
    pin_step(2, 1'b0, 16'h2000);
    pin_step(3, 1'b1, 16'h4000);
    rd_chk("status level", ADDR_STATUS, 16'h4000);
    pin_step(3, 1'b0, 16'h4000);
    rd_chk("status idle", ADDR_STATUS, 16'h0000);
    pin_cfg[1].func = FN_IRQ_OUT;
    @(negedge sys_clk) core_events = 5'b10000;
    @(negedge sys_clk) core_events = '0;
    irq_chk(1'b1);
    chk("pin oe_n", {12'h0, pin_irq_oe_n}, 16'h000d);
    chk("pin wire", {15'h0, pin_wire[1]}, 16'h0001);
    chk("host seen", {15'h0, irq_seen}, 16'h0001);
    reg_rd(ADDR_STATUS, d);
    irq_chk(1'b0);
    chk("pin out", {12'h0, pin_irq_out}, 16'h0000);
    reg_wr(ADDR_MASK, 16'h0100);
    @(negedge sys_clk) core_events = 5'b10000;
    @(negedge sys_clk) core_events = '0;
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    chk("irq reset", {15'h0, irq_out}, 16'h0000);
    chk("oe_n reset", {12'h0, pin_irq_oe_n}, 16'h000f);
    rd_chk("status reset", ADDR_STATUS, 16'h0000);
    rd_chk("mask reset", ADDR_MASK, 16'h0000);
    rd_chk("config reset", ADDR_CONFIG, 16'h0001);
    give_verdict;
  end
endmodule
